// *** dv/flash_model.sv ***
// flash array side: counts commands and keeps the last one
`timescale 1ns/10ps
`default_nettype none
module flash_model
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  output logic [7:0] cmd_count,
  output logic [2:0] last_op,
  output logic [23:0] last_addr
);
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cmd_count <= 8'h00;
    else if (cmd_valid)
      cmd_count <= cmd_count + 8'h01;
    if (cmd_valid)
    begin
      last_op <= cmd_op;
      last_addr <= cmd_addr;
    end
  end
endmodule : flash_model
`default_nettype wire

// *** dv/flash_seq_bench.sv ***
// bench for the flash sequencer: bus tasks, operation table, lock and reset cases
`timescale 1ns/10ps
`default_nettype none
module flash_seq_bench;
  import flash_seq_pkg::*;
  localparam int CL = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic por_n = 1'b0;
  logic serprog_mode = 1'b0;
  logic [15:0] dlo;
  logic [7:0] dhi;
  logic [ROW_IDX_W-1:0] didx;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic cpu_stall, cmd_valid;
  logic [2:0] cmd_op, last_op;
  logic [23:0] cmd_addr, last_addr;
  logic [7:0] cmd_count, n0;
  logic [15:0] ctl [8] = '{16'hc001, 16'hc003, 16'hc042, 16'hc041, 16'hc002, 16'hc04f, 16'hc005, 16'h8001};
  logic [2:0] eop [8] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [23:0] ead [3] = '{24'h121200, 24'h121234, 24'h121000};
  int err_total = 0;
  int total_checks = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  flash_seq #(.CYCLE_LEN(CL)) flash_seq_inst (.clk_sys(clk_sys), .rstn(rstn), .por_n(por_n),
    .serprog_mode(serprog_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_stall(cpu_stall), .flash_cmd_valid(cmd_valid), .flash_cmd_op(cmd_op), .flash_cmd_addr(cmd_addr),
    .flash_data_lo(dlo), .flash_data_hi(dhi), .flash_data_idx(didx));
  flash_model flash_model_inst (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_count(cmd_count), .last_op(last_op), .last_addr(last_addr));
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
  endtask : acc
  task automatic wr1(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, a, d);
    acc(1'b0, 1'b0, a, d);
  endtask : wr1
  task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    acc(1'b0, 1'b1, a, 16'h0000);
    rd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, rdata & m});
    @(posedge clk_sys);
  endtask : rdc
  task automatic unl(input logic [15:0] v);
    acc(1'b1, 1'b0, OFF_KEY, KEY_FIRST);
    acc(1'b1, 1'b0, OFF_KEY, KEY_SECOND);
    wr1(OFF_CONTROL, v);
    acc(1'b0, 1'b0, OFF_CONTROL, v);
  endtask : unl
  task automatic wait_idle(output int c);
    c = 0;
    while (cpu_stall !== 1'b0 && c < 200)
    begin
      @(posedge clk_sys);
      c++;
    end
    if (c >= 200)
    begin
      err_total++;
      $display("unexpected cpu_stall exp 0 got 1");
    end
  endtask : wait_idle
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk_sys);
    rdc("ctrl reset", OFF_CONTROL, 16'hffff, CONTROL_RESET);
    rdc("key read", OFF_KEY, 16'hffff, 16'h0000);
    rdc("page reset", OFF_PAGE, 16'hffff, PAGE_RESET);
    $display("test reset done");
    wr1(OFF_CONTROL, 16'h4041);
    rdc("locked ctrl", OFF_CONTROL, 16'hffff, 16'h0000);
    acc(1'b1, 1'b0, OFF_KEY, KEY_FIRST);
    acc(1'b0, 1'b1, OFF_PAGE, 16'h0000);
    acc(1'b1, 1'b0, OFF_KEY, KEY_SECOND);
    wr1(OFF_CONTROL, 16'h4041);
    rdc("broken key", OFF_CONTROL, 16'hffff, 16'h0000);
    unl(16'h5fb1);
    rdc("unused bits", OFF_CONTROL, 16'hffff, 16'h4001);
    wr1(OFF_CONTROL, 16'hc001);
    rdc("stray start", OFF_CONTROL, 16'ha000, 16'h2000);
    $display("test lock done");
    // latches are loaded from the aligned group before any start
    wr1(OFF_PAGE, 16'h0012);
    wr1(OFF_ADDR, 16'h1234);
    acc(1'b1, 1'b0, OFF_TBL_LO, 16'hbeef);
    wr <= 1'b0;
    #1;
    chk("tbl stall", 24'h1, {23'h0, cpu_stall});
    @(posedge clk_sys);
    wait_idle(n);
    chk("tbl length", 24'h1, 24'(n));
    wr1(OFF_TBL_HI, 16'h00a5);
    $display("test latch done");
    for (int i = 0; i < 8; i++)
    begin
      n0 = cmd_count;
      unl(ctl[i]);
      wait_idle(n);
      chk("op", {21'h0, eop[i]}, {21'h0, (cmd_count != n0) ? last_op : 3'h0});
      if (i == 1)
        chk("word data", 24'ha5beef, {dhi, dlo});
      if (i == 1)
        chk("word index", 24'h00001a, {18'h0, didx});
      if (i < 3)
        chk("target", ead[i], last_addr);
      if (i < 3)
        chk("cycle", 24'h1, {23'h0, n >= CL - 2 && n <= CL});
      rdc("done flags", OFF_CONTROL, 16'ha000, (i < 3) ? 16'h0000 : 16'h2000);
    end
    serprog_mode <= 1'b1;
    repeat (6) @(posedge clk_sys);
    n0 = cmd_count;
    unl(16'hc04f);
    wait_idle(n);
    chk("bulk op", 24'h4, {21'h0, (cmd_count != n0) ? last_op : 3'h0});
    serprog_mode <= 1'b0;
    repeat (6) @(posedge clk_sys);
    $display("test ops done");
    unl(16'hc001);
    unl(16'h4001);
    rdc("start kept", OFF_CONTROL, 16'h8000, 16'h8000);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdc("abort flags", OFF_CONTROL, 16'he04f, 16'h6001);
    $display("test abort done");
    end_sim();
  end
endmodule : flash_seq_bench
bind flash_seq flash_seq_checker #(.CYCLE_LEN(CYCLE_LEN)) chk_inst (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_stall(cpu_stall), .flash_cmd_valid(flash_cmd_valid),
  .flash_cmd_op(flash_cmd_op));
`default_nettype wire

// *** dv/flash_seq_checker.sv ***
// port assertions for the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_seq_checker
  import flash_seq_pkg::*;
#(
  parameter int CYCLE_LEN = 20
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic cpu_stall,
  input wire logic flash_cmd_valid,
  input wire logic [2:0] flash_cmd_op
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic key2_q;
  logic go_q;
  logic [31:0] stall_cnt;
  // helpers look back one cycle so no expression goes through $past
  always_ff @(posedge clk_sys)
  begin
    key2_q <= rstn && wr && addr == OFF_KEY && wdata == KEY_SECOND;
    go_q <= rstn && key2_q && wr && addr == OFF_CONTROL && wdata[15];
    stall_cnt <= (cpu_stall && rstn) ? stall_cnt + 32'h1 : 32'h0;
  end
  sequence key_pair;
    wr && addr == OFF_KEY && wdata == KEY_FIRST ##1 wr && addr == OFF_KEY && wdata == KEY_SECOND;
  endsequence
  sequence row_start;
    wr && addr == OFF_CONTROL && wdata[15:14] == 2'b11 && wdata[6:0] == 7'h01 && !cpu_stall;
  endsequence
  chk_unlock_start: assert property (key_pair ##1 row_start |=> flash_cmd_valid && flash_cmd_op == FL_PROG_ROW)
    else $error("row start after unlock gave no command");
  chk_locked_cmd: assert property (flash_cmd_valid |-> go_q)
    else $error("command without unlocked start write");
  chk_cmd_pulse: assert property (flash_cmd_valid |=> !flash_cmd_valid)
    else $error("command pulse longer than one cycle");
  chk_stall_held: assert property (flash_cmd_valid |-> cpu_stall ##1 cpu_stall[*7])
    else $error("stall dropped early");
  chk_stall_bound: assert property (stall_cnt <= CYCLE_LEN + 4)
    else $error("stall lasted too long");
  chk_no_enable: assert property (wr && addr == OFF_CONTROL && wdata[15] && !wdata[14] |=> !flash_cmd_valid)
    else $error("command with enable clear");
  chk_bad_op: assert property (wr && addr == OFF_CONTROL && (wdata[3:0] == 4'h5 || wdata[6:0] == 7'h41)
    |=> !flash_cmd_valid)
    else $error("command for invalid operation");
  chk_key_read: assert property (rd && addr == OFF_KEY |=> rdata == 16'h0000)
    else $error("key register readable");
  chk_unused_zero: assert property (rd && addr == OFF_CONTROL |=> (rdata & ~CONTROL_MASK) == 16'h0000)
    else $error("unused control bits not zero");
endmodule : flash_seq_checker
`default_nettype wire

// *** inc/flash_seq_pkg.sv ***
// constants and types for the self-programming flash sequencer
package flash_seq_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_KEY = 4'h2;
  localparam logic [3:0] OFF_PAGE = 4'h4;
  localparam logic [3:0] OFF_TBL_LO = 4'h6;
  localparam logic [3:0] OFF_TBL_HI = 4'h8;
  localparam logic [3:0] OFF_ADDR = 4'ha;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  localparam logic [3:0] OFF_SERPROG = 4'he;
  localparam int START_BIT = 15;
  localparam int ENABLE_BIT = 14;
  localparam int ERROR_BIT = 13;
  localparam int ERASE_BIT = 6;
  localparam logic [15:0] CONTROL_MASK = 16'he04f;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PAGE_RESET = 16'h0000;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;
  localparam logic [3:0] OP_ROW_PROG = 4'h1;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
  localparam logic [3:0] OP_WORD_PROG = 4'h3;
  localparam logic [3:0] OP_BULK_ERASE = 4'hf;
  localparam int ROW_WORDS = 64;
  localparam int ROW_BYTES = 192;
  localparam int BLOCK_ROWS = 8;
  localparam int BLOCK_BYTES = 1536;
  localparam int ROW_IDX_W = 6;
  localparam int CLK_MHZ = 100;
  localparam int CYCLE_US = 4000;
  localparam int CYCLE_COUNT = CYCLE_US * CLK_MHZ;
  localparam int TBL_WRITE_CYCLES = 2;
  typedef enum logic [2:0] {
    FL_IDLE,
    FL_PROG_ROW,
    FL_PROG_WORD,
    FL_ERASE_PAGE,
    FL_ERASE_BULK
  } flash_op_t;
  typedef struct packed {
    logic valid;
    flash_op_t op;
    logic [23:0] addr;
  } flash_cmd_t;
endpackage : flash_seq_pkg

// *** rtl/flash_seq.sv ***
// run-time self-programming flash sequencer: key unlock, control register, latches, timed cycle
`timescale 1ns/10ps
`default_nettype none
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int CYCLE_LEN = CYCLE_COUNT
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic serprog_mode,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic cpu_stall,
  output logic flash_cmd_valid,
  output logic [2:0] flash_cmd_op,
  output logic [23:0] flash_cmd_addr,
  output logic [15:0] flash_data_lo,
  output logic [7:0] flash_data_hi,
  output logic [ROW_IDX_W-1:0] flash_data_idx
);

  logic [15:0] control_reg;
  logic [15:0] page_reg;
  logic [1:0] key_state_reg;
  logic unlock_reg;
  logic [31:0] timer_reg;
  flash_op_t op_reg;
  logic [23:0] row_addr_reg;
  logic [15:0] latch_lo [ROW_WORDS];
  logic [7:0] latch_hi [ROW_WORDS];
  logic [15:0] eff_addr_reg;
  logic [1:0] tbl_busy_reg;
  logic [ROW_IDX_W-1:0] drain_idx_reg;
  logic serprog_s1, serprog_s2, serprog_s3, serprog_ok;

  // serial programming strap is asynchronous to the core clock
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      serprog_s1 <= 1'b0;
      serprog_s2 <= 1'b0;
      serprog_s3 <= 1'b0;
      serprog_ok <= 1'b0;
    end
    else
    begin
      serprog_s1 <= serprog_mode;
      serprog_s2 <= serprog_s1;
      serprog_s3 <= serprog_s2;
      if (serprog_s2 == serprog_s3)
        serprog_ok <= serprog_s3;
    end
  end

  wire busy = control_reg[START_BIT];
  wire wr_ctrl = wr && (addr == OFF_CONTROL);
  wire wr_key = wr && (addr == OFF_KEY);
  wire [3:0] op_field = wdata[3:0];
  wire erase_sel = wdata[ERASE_BIT];

  // decode requested op from the value being written
  flash_op_t req_op;
  always_comb
  begin
    req_op = FL_IDLE;
    case (op_field)
      OP_ROW_PROG: req_op = erase_sel ? FL_IDLE : FL_PROG_ROW;
      OP_WORD_PROG: req_op = erase_sel ? FL_IDLE : FL_PROG_WORD;
      OP_PAGE_ERASE: req_op = erase_sel ? FL_ERASE_PAGE : FL_IDLE;
      OP_BULK_ERASE: req_op = (erase_sel && serprog_ok) ? FL_ERASE_BULK : FL_IDLE;
      default: req_op = FL_IDLE;
    endcase
  end

  wire start_req = wr_ctrl && wdata[START_BIT] && !busy;
  wire start_ok = start_req && unlock_reg && wdata[ENABLE_BIT] && (req_op != FL_IDLE);
  wire done = busy && (timer_reg == 32'h0000_0001);

  // key sequence: 55 then aa in back-to-back key writes
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      key_state_reg <= 2'h0;
      unlock_reg <= 1'b0;
    end
    else
    begin
      unlock_reg <= 1'b0;
      if (wr_key && wdata == KEY_FIRST)
        key_state_reg <= 2'h1;
      else if (wr_key && wdata == KEY_SECOND && key_state_reg == 2'h1)
      begin
        key_state_reg <= 2'h0;
        unlock_reg <= 1'b1;
      end
      else if (wr || rd)
        key_state_reg <= 2'h0;
    end
  end

  // control register survives warm reset except the start and error bits of a running cycle; only por_n clears it
  always_ff @(posedge clk_sys)
  begin
    if (!por_n)
      control_reg <= CONTROL_RESET;
    else
    begin
      if (wr_ctrl && unlock_reg && !busy)
      begin
        control_reg[ENABLE_BIT] <= wdata[ENABLE_BIT];
        control_reg[ERASE_BIT] <= wdata[ERASE_BIT];
        control_reg[3:0] <= wdata[3:0];
      end
      if (start_ok)
      begin
        control_reg[START_BIT] <= 1'b1;
        control_reg[ERROR_BIT] <= 1'b0;
      end
      else if (start_req)
        control_reg[ERROR_BIT] <= 1'b1;
      else if (done)
        control_reg[START_BIT] <= 1'b0;
      else if (!rstn && busy)
      begin
        // warm reset mid-cycle aborts it: an improper termination
        control_reg[START_BIT] <= 1'b0;
        control_reg[ERROR_BIT] <= 1'b1;
      end
    end
  end

  // self-timed cycle with processor stall
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      timer_reg <= 32'h0;
      op_reg <= FL_IDLE;
    end
    else if (start_ok)
    begin
      timer_reg <= 32'(CYCLE_LEN);
      op_reg <= req_op;
    end
    else if (timer_reg != 32'h0)
      timer_reg <= timer_reg - 32'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      page_reg <= PAGE_RESET;
    else if (wr && addr == OFF_PAGE)
      page_reg <= {8'h00, wdata[7:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      eff_addr_reg <= 16'h0;
    else if (wr && addr == OFF_ADDR)
      eff_addr_reg <= wdata;
  end

  // table write: latches only, two instruction cycles each
  wire [23:0] tbl_addr = {page_reg[7:0], eff_addr_reg[15:1], 1'b0};
  wire [ROW_IDX_W-1:0] word_idx = eff_addr_reg[ROW_IDX_W:1];
  // a load landing in the previous load's stall cycle is refused, as the core cannot issue it
  wire tbl_wr = wr && (addr == OFF_TBL_LO || addr == OFF_TBL_HI) && !busy && (tbl_busy_reg == 2'h0);
  always_ff @(posedge clk_sys)
  begin
    if (tbl_wr && addr == OFF_TBL_LO)
      latch_lo[word_idx] <= wdata;
    if (tbl_wr && addr == OFF_TBL_HI)
      latch_hi[word_idx] <= wdata[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      tbl_busy_reg <= 2'h0;
    else if (tbl_wr)
      tbl_busy_reg <= 2'(TBL_WRITE_CYCLES - 1);
    else if (tbl_busy_reg != 2'h0)
      tbl_busy_reg <= tbl_busy_reg - 2'h1;
  end

  // row target remembered from the latch loads
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      row_addr_reg <= 24'h0;
    else if (tbl_wr)
      row_addr_reg <= {tbl_addr[23:ROW_IDX_W+1], {(ROW_IDX_W+1){1'b0}}};
  end

  // command and data toward the flash array
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      flash_cmd_valid <= 1'b0;
      flash_cmd_op <= 3'h0;
      flash_cmd_addr <= 24'h0;
      drain_idx_reg <= '0;
    end
    else
    begin
      flash_cmd_valid <= start_ok;
      if (start_ok)
      begin
        flash_cmd_op <= req_op;
        drain_idx_reg <= '0;
        case (req_op)
          FL_PROG_ROW: flash_cmd_addr <= row_addr_reg;
          FL_ERASE_PAGE: flash_cmd_addr <= {tbl_addr[23:ROW_IDX_W+4], {(ROW_IDX_W+4){1'b0}}};
          default: flash_cmd_addr <= tbl_addr;
        endcase
      end
      else if (busy && op_reg == FL_PROG_ROW)
        drain_idx_reg <= drain_idx_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      flash_data_lo <= 16'h0;
      flash_data_hi <= 8'h0;
      flash_data_idx <= '0;
    end
    else
    begin
      flash_data_idx <= (op_reg == FL_PROG_WORD) ? word_idx : drain_idx_reg;
      flash_data_lo <= latch_lo[(op_reg == FL_PROG_WORD) ? word_idx : drain_idx_reg];
      flash_data_hi <= latch_hi[(op_reg == FL_PROG_WORD) ? word_idx : drain_idx_reg];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cpu_stall <= 1'b0;
    else
      cpu_stall <= start_ok || (busy && !done) || tbl_wr;
  end

  // read port; key register reads zero
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rdata <= 16'h0;
    else if (!rd)
      rdata <= 16'h0;
    else if (addr == OFF_CONTROL)
      rdata <= control_reg & CONTROL_MASK;
    else if (addr == OFF_KEY)
      rdata <= 16'h0;
    else if (addr == OFF_PAGE)
      rdata <= page_reg;
    else if (addr == OFF_ADDR)
      rdata <= eff_addr_reg;
    else if (addr == OFF_STATUS)
      rdata <= {14'h0, serprog_ok, unlock_reg};
    else
      rdata <= 16'h0;
  end

endmodule : flash_seq
`default_nettype wire
